/* File: pcb_cfg_header.sv */
// Purpose: bridge configuration header registers on an AHB-Lite slave
// Assumes: single word transfers, clk at 100 MHz, events are one-cycle pulses
// Notes: status events also drive a masked interrupt
//
// Register access over AHB-Lite was left to the implementer.
`include "pcb_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module pcb_cfg_header
#(
  // arbitrary neutral value
  parameter logic [7:0] REVISION = 8'h00
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic evt_parity_err,
  input wire logic evt_cpl_abort_sent,
  input wire logic evt_cpl_abort_rcvd,
  input wire logic evt_cpl_ur_rcvd,
  input wire logic evt_err_msg_sent,
  input wire logic evt_poisoned_rcvd,
  output logic parity_resp_en,
  output logic system_error_report_enable,
  output logic [7:0] upstream_bus_index,
  output logic [7:0] downstream_bus_index,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pcb_pkg::pcb_phase_e phase;
    logic [5:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic perr_resp;
    logic serr_en;
    logic [7:0] line_size;
    logic [7:0] up_bus;
    logic [7:0] dn_bus;
    logic [`PCB_NUM_EVT-1:0] mask;
    logic irq;
  } pcb_state_s;

  pcb_state_s st_r;
  pcb_state_s st_nxt;
  logic [`PCB_NUM_EVT-1:0] evt_set;
  logic [`PCB_NUM_EVT-1:0] evt_clr;
  logic [`PCB_NUM_EVT-1:0] flags;
  logic [31:0] status_word;
  logic wr_cmd;
  logic wr_istat;
  logic addr_ok;

  // ****************************************
  // sticky status flags
  // ****************************************
  // flag order: mdpe, sta, rta, rma, sse, dpe
  always_comb
  begin
    evt_set[0] = evt_parity_err & st_r.perr_resp;
    evt_set[1] = evt_cpl_abort_sent;
    evt_set[2] = evt_cpl_abort_rcvd;
    evt_set[3] = evt_cpl_ur_rcvd;
    evt_set[4] = evt_err_msg_sent & st_r.serr_en;
    evt_set[5] = evt_poisoned_rcvd;
  end

  assign wr_cmd = (st_r.phase == pcb_pkg::PCB_DATA) && st_r.wr &&
                  (st_r.addr == `PCB_OFF_CMDSTAT);
  assign wr_istat = (st_r.phase == pcb_pkg::PCB_DATA) && st_r.wr &&
                    (st_r.addr == `PCB_OFF_IRQ_STAT);

  always_comb
  begin
    evt_clr = {`PCB_NUM_EVT{1'b0}};
    if (wr_cmd)
      evt_clr = {hwdata[`PCB_BIT_DPE], hwdata[`PCB_BIT_SSE], hwdata[`PCB_BIT_RMA],
                 hwdata[`PCB_BIT_RTA], hwdata[`PCB_BIT_STA], hwdata[`PCB_BIT_MDPE]};
    else if (wr_istat)
      evt_clr = hwdata[`PCB_NUM_EVT-1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCB_NUM_EVT; gi = gi + 1)
    begin : g_flag
      pcb_w1c_bit u_flag
      (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .set(evt_set[gi]),
        .clr(evt_clr[gi]),
        .q(flags[gi])
      );
    end
  endgenerate

  // ****************************************
  // read view of the command and status word
  // ****************************************
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`PCB_BIT_PERR_RESP] = st_r.perr_resp;
    status_word[`PCB_BIT_SERR_EN] = st_r.serr_en;
    status_word[`PCB_BIT_INTX] = 1'b0;
    status_word[`PCB_BIT_CAPLIST] = 1'b1;
    status_word[`PCB_BIT_MDPE] = flags[0];
    status_word[`PCB_BIT_STA] = flags[1];
    status_word[`PCB_BIT_RTA] = flags[2];
    status_word[`PCB_BIT_RMA] = flags[3];
    status_word[`PCB_BIT_SSE] = flags[4];
    status_word[`PCB_BIT_DPE] = flags[5];
  end

  assign addr_ok = (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'h0);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.irq = |(flags & st_r.mask);
    // data phase: apply writes
    if (st_r.phase == pcb_pkg::PCB_DATA)
    begin
      st_nxt.phase = pcb_pkg::PCB_IDLE;
      if (st_r.wr)
      begin
        case (st_r.addr)
          `PCB_OFF_CMDSTAT:
          begin
            st_nxt.perr_resp = hwdata[`PCB_BIT_PERR_RESP];
            st_nxt.serr_en = hwdata[`PCB_BIT_SERR_EN];
          end
          `PCB_OFF_LINEHDR:
          begin
            st_nxt.line_size = hwdata[7:0];
          end
          `PCB_OFF_BUSNUM:
          begin
            st_nxt.up_bus = hwdata[7:0];
            st_nxt.dn_bus = hwdata[15:8];
          end
          `PCB_OFF_IRQ_MASK:
          begin
            st_nxt.mask = hwdata[`PCB_NUM_EVT-1:0];
          end
          default:
          begin
            st_nxt.wr = st_r.wr;
          end
        endcase
      end
    end
    // address phase
    if (hsel && hready && (htrans == `PCB_HTRANS_NONSEQ))
    begin
      st_nxt.phase = pcb_pkg::PCB_DATA;
      st_nxt.wr = hwrite;
      st_nxt.addr = addr_ok ? haddr[5:0] : 6'h3f;
      st_nxt.rdata = 32'h0000_0000;
      if (!hwrite && addr_ok && (hsize == `PCB_HSIZE_WORD))
      begin
        case (haddr[5:0])
          `PCB_OFF_CMDSTAT:
            st_nxt.rdata = status_word;
          `PCB_OFF_REVCLASS:
            st_nxt.rdata = {`PCB_BASE_CLASS, `PCB_SUB_CLASS, `PCB_PROG_IF, REVISION};
          `PCB_OFF_LINEHDR:
            // header type and zero latency byte
            st_nxt.rdata = {`PCB_BYTE_ZERO, `PCB_HDR_TYPE, `PCB_BYTE_ZERO, st_r.line_size};
          `PCB_OFF_BUSNUM:
            st_nxt.rdata = {`PCB_BYTE_ZERO, `PCB_BYTE_ZERO, st_r.dn_bus, st_r.up_bus};
          `PCB_OFF_IRQ_STAT:
            st_nxt.rdata = {{(32-`PCB_NUM_EVT){1'b0}}, flags};
          `PCB_OFF_IRQ_MASK:
            st_nxt.rdata = {{(32-`PCB_NUM_EVT){1'b0}}, st_r.mask};
          default:
            st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.phase <= pcb_pkg::PCB_IDLE;
      st_r.addr <= 6'h00;
      st_r.wr <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.perr_resp <= 1'b0;
      st_r.serr_en <= 1'b0;
      st_r.line_size <= 8'h00;
      st_r.up_bus <= 8'h00;
      st_r.dn_bus <= 8'h00;
      st_r.mask <= 6'h00;
      st_r.irq <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign parity_resp_en = st_r.perr_resp;
  assign system_error_report_enable = st_r.serr_en;
  assign upstream_bus_index = st_r.up_bus;
  assign downstream_bus_index = st_r.dn_bus;
  assign irq = st_r.irq;
endmodule
`default_nettype wire

/* File: pcb_cfg_header_monitor.sv */
// Purpose: port checks of the bridge header bank
// Assumes: zero wait states, word transfers only
// Notes: bound to every bank instance
`timescale 1ns/1ns
`default_nettype none
module pcb_cfg_header_monitor
#(
  parameter logic [7:0] REVISION = 8'h00
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic parity_resp_en,
  input wire logic system_error_report_enable,
  input wire logic [7:0] upstream_bus_index,
  input wire logic [7:0] downstream_bus_index
);
  // ****
  // accepted address phases
  // ****
  logic acc;
  assign acc = ce && hsel && hready && htrans == 2'h2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_rst;
    $rose(rst_n) |-> !parity_resp_en && !system_error_report_enable
      && {upstream_bus_index, downstream_bus_index} == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_rd_stat;
    acc && !hwrite && haddr == 32'h04 |=> hrdata[23:16] == 8'h10 && hrdata[26:25] == 2'h0;
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("fixed status bits");
  property p_rd_rev;
    acc && !hwrite && haddr == 32'h08 |=> hrdata[7:0] == REVISION;
  endproperty
  a_rd_rev: assert property (p_rd_rev) else $error("revision byte");
  property p_rd_class;
    acc && !hwrite && haddr == 32'h08 |=> hrdata[31:8] == 24'h060400;
  endproperty
  a_rd_class: assert property (p_rd_class) else $error("class code");
  property p_rd_hdr;
    acc && !hwrite && haddr == 32'h0c |=> hrdata[31:8] == 24'h000100;
  endproperty
  a_rd_hdr: assert property (p_rd_hdr) else $error("header type word");
  property p_rd_bus;
    acc && !hwrite && haddr == 32'h18 |=>
      hrdata == {16'h0000, $past(downstream_bus_index), $past(upstream_bus_index)};
  endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("bus number read");
  property p_ctl_wr;
    acc && hwrite && haddr == 32'h04 ##1 ce |=> parity_resp_en == $past(hwdata[6])
      && system_error_report_enable == $past(hwdata[8]);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write");
  property p_bus_wr;
    acc && hwrite && haddr == 32'h18 ##1 ce |=>
      {downstream_bus_index, upstream_bus_index} == $past(hwdata[15:0]);
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("bus number write");
endmodule
bind pcb_cfg_header pcb_cfg_header_monitor #(.REVISION(REVISION)) u_mon
(
  .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .parity_resp_en, .system_error_report_enable, .upstream_bus_index, .downstream_bus_index
);
`default_nettype wire

/* File: pcb_defines.svh */
// Purpose: constants of the bridge configuration header bank
// Assumes: 32-bit AHB-Lite words, byte addresses as printed
// Notes: included by bare name
`ifndef PCB_DEFINES_SVH
`define PCB_DEFINES_SVH
`define PCB_OFF_CMDSTAT 6'h04
`define PCB_OFF_REVCLASS 6'h08
`define PCB_OFF_LINEHDR 6'h0c
`define PCB_OFF_BUSNUM 6'h18
`define PCB_OFF_IRQ_STAT 6'h30
`define PCB_OFF_IRQ_MASK 6'h34
`define PCB_BIT_PERR_RESP 6
`define PCB_BIT_SERR_EN 8
`define PCB_BIT_INTX 19
`define PCB_BIT_CAPLIST 20
`define PCB_BIT_MDPE 24
`define PCB_BIT_STA 27
`define PCB_BIT_RTA 28
`define PCB_BIT_RMA 29
`define PCB_BIT_SSE 30
`define PCB_BIT_DPE 31
`define PCB_PROG_IF 8'h00
`define PCB_SUB_CLASS 8'h04
`define PCB_BASE_CLASS 8'h06
`define PCB_HDR_TYPE 8'h01
`define PCB_BYTE_ZERO 8'h00
`define PCB_NUM_EVT 6
`define PCB_HTRANS_NONSEQ 2'h2
`define PCB_HSIZE_WORD 3'h2
`endif

/* File: pcb_host_model.sv */
// Purpose: upstream configuration master on the AHB-Lite port
// Assumes: one slave, single word transfers
// Notes: xfer is called just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module pcb_host_model
(
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ****
  // single transfers
  // ****
  initial
  begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  end
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // unused data lines toggle rather than keep the old word
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: pcb_pkg.sv */
// Purpose: types of the bridge configuration header bank
// Assumes: nothing
// Notes: none
package pcb_pkg;
  typedef enum logic [0:0] {PCB_IDLE, PCB_DATA} pcb_phase_e;
endpackage

/* File: pcb_w1c_bit.sv */
// Purpose: one sticky status flag, set by hardware, cleared by writing one
// Assumes: set and clear are one-cycle qualified strobes
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module pcb_w1c_bit
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // ****************************************
  // flag
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= 1'b0;
    else if (ce)
    begin
      if (set)
        q <= 1'b1;
      else if (clr)
        q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test_pcb_cfg_header.sv */
// Purpose: self-checking bench of the bridge header bank
// Assumes: zero wait-state slave, events as one-cycle pulses
// Notes: reset reads first, then register rows, then event, interrupt, clock enable and reset cases
`timescale 1ns/1ns
`default_nettype none
module test_pcb_cfg_header;
  // arbitrary revision value
  localparam logic [7:0] REV = 8'h3c;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e; logic [31:0] m;} pcb_row_s;
  logic clk, rst_n, ce, hsel, hwrite, hreadyout, irq, perr_en, serr_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] ev;
  logic [7:0] up_bus, dn_bus;
  logic [31:0] haddr, hwdata, hrdata, q;
  int err_count, n_tests;
  pcb_row_s rows [6] = '{'{32'h08, 32'hffffffff, {24'h060400, REV}, 32'hffffffff},
    '{32'h0c, 32'hffffffff, 32'h000100ff, 32'hffffffff},
    '{32'h18, 32'hffffa55a, 32'h0000a55a, 32'hffffffff},
    '{32'h04, 32'h00000140, 32'h00100140, 32'h07f80140},
    '{32'h28, 32'hffffffff, 32'h00000000, 32'hffffffff},
    '{32'h34, 32'hffffffff, 32'h0000003f, 32'hffffffff}};
  pcb_cfg_header #(.REVISION(REV)) dut
  (
    .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .evt_parity_err(ev[0]),
    .evt_cpl_abort_sent(ev[1]), .evt_cpl_abort_rcvd(ev[2]), .evt_cpl_ur_rcvd(ev[3]),
    .evt_err_msg_sent(ev[4]), .evt_poisoned_rcvd(ev[5]), .parity_resp_en(perr_en),
    .system_error_report_enable(serr_en), .upstream_bus_index(up_bus),
    .downstream_bus_index(dn_bus), .irq
  );
  pcb_host_model host
  (
    .clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata
  );
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [31:0] a);
    host.xfer(a, 1'b0, 32'h0, q);
  endtask
  task automatic pulse(input logic [5:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #50us;
    err_count++;
    stop_test();
  end
  // ****
  // tests
  // ****
  initial
  begin
    {rst_n, ce, ev, err_count, n_tests} = '0;
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(32'h04);
    chk(q, 32'h00100000, "status at reset");
    rd(32'h18);
    chk(q, 32'h0, "bus at reset");
    rd(32'h0c);
    chk(q, 32'h00010000, "line at reset");
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(q & rows[i].m, rows[i].e, "row");
      $display("row %0d done", i);
    end
    pulse(6'h3f);
    rd(32'h04);
    chk(q, 32'hf9100140, "flags set");
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(32'h04, 32'hf9000000);
    rd(32'h04);
    chk(q, 32'h00100000, "flags cleared");
    chk({31'h0, irq}, 32'h0, "irq dropped");
    pulse(6'h11);
    rd(32'h04);
    chk(q, 32'h00100000, "gated flags");
    $display("event test done");
    wr(32'h34, 32'h0);
    pulse(6'h20);
    rd(32'h30);
    chk(q, 32'h20, "irq status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(32'h34, 32'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(32'h30, 32'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("interrupt test done");
    ce <= 1'b0;
    pulse(6'h20);
    ce <= 1'b1;
    rd(32'h30);
    chk(q, 32'h0, "event while frozen");
    $display("clock enable test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({16'h0, dn_bus, up_bus}, 32'h0, "bus after reset");
    chk({31'h0, perr_en}, 32'h0, "control after reset");
    rst_n <= 1'b1;
    @(posedge clk);
    $display("second reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
